// file: hdl/timer8_counter_capture.sv
// 8-bit free-running timer with prescaler, overflow and two captures
//
// What this block does
// R01 - Tick: CPU/2, /4, /8 or osc/8000
// R02 - 8-bit up-counter, wraps freely
// R03 - Alternate count read never clears overflow
// R04 - Any count register write loads FCh
// R05 - FCh is the only reload value
// R06 - Periods 512, 1024, 2048 CPU cycles
// R07 - Overflow flag set on FFh to 00h
// R08 - Overflow request: flag, enable, mask clear
// R09 - Status read then main count access clears
// R10 - Wait state does not affect timer
// R11 - Halt freezes count; reset reloads
// R12 - Unbonded capture pin reads as one
// R13 - Capture copies count on active edge
// R14 - Each channel has own edge select
// R15 - Edge select 0 falling, 1 rising
// R16 - Capture sets channel flag, loads value
// R17 - Shared capture enable covers both flags
// R18 - Status read then capture access clears
// R19 - Newer capture overwrites older value
// R20 - Waveform modes: only channel two captures
// R21 - Capture pins always feed the timer
// R22 - Set wins over simultaneous clear
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module timer8_counter_capture #(
  parameter int OSC_DIV = timer8_pkg::OSC_DIV_DEFAULT,
  parameter bit CAP_ONE_BONDED = 1'b1,
  parameter bit CAP_TWO_BONDED = 1'b1
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_CPU_IRQ_MASK,
  input wire logic I_HALT,
  input wire logic I_OSC_CLK,
  input wire logic I_CAPTURE_PIN_ONE,
  input wire logic I_CAPTURE_PIN_TWO,
  output logic O_OVF_IRQ,
  output logic O_CAP_IRQ
);

  localparam int OSC_W = $clog2(OSC_DIV);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
  localparam logic [1:0] BONDED = {CAP_TWO_BONDED, CAP_ONE_BONDED};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, timer8_pkg::OFF_CTRL_ONE) ||
             hit(a, timer8_pkg::OFF_CTRL_TWO) ||
             hit(a, timer8_pkg::OFF_STATUS) ||
             hit(a, timer8_pkg::OFF_CAP_ONE) ||
             hit(a, timer8_pkg::OFF_MAIN_COUNT) ||
             hit(a, timer8_pkg::OFF_ALT_COUNT) ||
             hit(a, timer8_pkg::OFF_CAP_TWO);
  endfunction

  logic [7:0] count;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic [2:0] flags;
  logic [2:0] armed;
  logic [2:0] set_evt;
  logic [2:0] clr_evt;
  logic [7:0] cap_val [2];
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] rd_value;
  logic [7:0] status_view;
  logic [2:0] cpu_div;
  logic [OSC_W-1:0] osc_cnt;
  logic osc_s1;
  logic osc_s2;
  logic osc_prev;
  logic osc_edge;
  logic tick;
  logic reload;
  logic ovf_evt;
  logic wave_mode;
  logic [1:0] active_edge;
  logic [1:0] cap_evt;
  logic wr_do;
  logic rd_do;
  logic wr_ctrl1, wr_ctrl2, wr_main, wr_alt, wr_cap1, wr_cap2;
  logic rd_status, rd_main, rd_cap1, rd_cap2;

  // AXI4-Lite write side: address and data taken in either order
  assign wr_do = !O_AWREADY && !O_WREADY && !O_BVALID;
  assign rd_do = I_ARVALID && O_ARREADY;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AWREADY <= 1'b1;
      aw_addr <= 8'h00;
    end else if (I_AWVALID && O_AWREADY) begin
      O_AWREADY <= 1'b0;
      aw_addr <= I_AWADDR;
    end else if (O_BVALID && I_BREADY) begin
      O_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WREADY <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      O_WREADY <= 1'b0;
      w_data <= I_WDATA;
      w_strb <= I_WSTRB;
    end else if (O_BVALID && I_BREADY) begin
      O_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BVALID <= 1'b0;
      O_BRESP <= timer8_pkg::RESP_OKAY;
    end else if (wr_do) begin
      O_BVALID <= 1'b1;
      O_BRESP <= mapped(aw_addr) ? timer8_pkg::RESP_OKAY :
                 timer8_pkg::RESP_SLVERR;
    end else if (O_BVALID && I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= timer8_pkg::RESP_OKAY;
    end else if (rd_do) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= {24'h00_0000, rd_value};
      O_RRESP <= mapped(I_ARADDR) ? timer8_pkg::RESP_OKAY :
                 timer8_pkg::RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  assign wr_ctrl1 = wr_do && hit(aw_addr, timer8_pkg::OFF_CTRL_ONE);
  assign wr_ctrl2 = wr_do && hit(aw_addr, timer8_pkg::OFF_CTRL_TWO);
  assign wr_main = wr_do && hit(aw_addr, timer8_pkg::OFF_MAIN_COUNT);
  assign wr_alt = wr_do && hit(aw_addr, timer8_pkg::OFF_ALT_COUNT);
  assign wr_cap1 = wr_do && hit(aw_addr, timer8_pkg::OFF_CAP_ONE);
  assign wr_cap2 = wr_do && hit(aw_addr, timer8_pkg::OFF_CAP_TWO);
  assign rd_status = rd_do && hit(I_ARADDR, timer8_pkg::OFF_STATUS);
  assign rd_main = rd_do && hit(I_ARADDR, timer8_pkg::OFF_MAIN_COUNT);
  assign rd_cap1 = rd_do && hit(I_ARADDR, timer8_pkg::OFF_CAP_ONE);
  assign rd_cap2 = rd_do && hit(I_ARADDR, timer8_pkg::OFF_CAP_TWO);

  always_comb begin
    status_view = 8'h00;
    status_view[timer8_pkg::SR_OVF] = flags[0];
    status_view[timer8_pkg::SR_CAP_ONE] = flags[1];
    status_view[timer8_pkg::SR_CAP_TWO] = flags[2];
  end

  always_comb begin
    case ({I_ARADDR[7:2], 2'b00})
      timer8_pkg::OFF_CTRL_ONE: rd_value = ctrl_one;
      timer8_pkg::OFF_CTRL_TWO: rd_value = ctrl_two;
      timer8_pkg::OFF_STATUS: rd_value = status_view;
      timer8_pkg::OFF_CAP_ONE: rd_value = cap_val[0];
      timer8_pkg::OFF_CAP_TWO: rd_value = cap_val[1];
      timer8_pkg::OFF_MAIN_COUNT: rd_value = count; // R03
      timer8_pkg::OFF_ALT_COUNT: rd_value = count; // R03
      default: rd_value = 8'h00;
    endcase
  end

  // Control registers; only byte lane 0 carries data
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_one <= timer8_pkg::CTRL_RESET;
    end else if (wr_ctrl1 && w_strb[0]) begin
      ctrl_one <= w_data[7:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_two <= timer8_pkg::CTRL_RESET;
    end else if (wr_ctrl2 && w_strb[0]) begin
      ctrl_two <= w_data[7:0];
    end
  end

  assign wave_mode = ctrl_two[timer8_pkg::CR2_SINGLE_PULSE] ||
                     ctrl_two[timer8_pkg::CR2_PWM];

  // Oscillator pin is asynchronous; must run below half the CPU clock
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_s1 <= I_OSC_CLK;
      osc_s2 <= osc_s1;
      osc_prev <= osc_s2;
    end
  end
  assign osc_edge = osc_s2 && !osc_prev;

  // Prescalers restart on reload so the first tick after it is a full one
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cpu_div <= 3'h0;
      osc_cnt <= '0;
    end else if (reload) begin
      cpu_div <= 3'h0;
      osc_cnt <= '0;
    end else if (!I_HALT) begin // R10 R11
      cpu_div <= cpu_div + 3'h1;
      if (osc_edge) begin
        osc_cnt <= (osc_cnt == OSC_LAST) ? '0 : osc_cnt + OSC_W'(1);
      end
    end
  end

  // Divide by 2, 4 or 8 gives 512, 1024 or 2048 cycles per wrap
  always_comb begin
    case (ctrl_two[timer8_pkg::CR2_TICK_LO +: 2])
      timer8_pkg::SEL_DIV2: tick = cpu_div[0]; // R01 R06
      timer8_pkg::SEL_DIV4: tick = &cpu_div[1:0]; // R01 R06
      timer8_pkg::SEL_DIV8: tick = &cpu_div; // R01 R06
      timer8_pkg::SEL_OSC: tick = osc_edge && (osc_cnt == OSC_LAST); // R01
      default: tick = 1'b0;
    endcase
    if (I_HALT) begin
      tick = 1'b0; // R11
    end
  end

  // In waveform modes an edge on pin one restarts the count
  assign reload = wr_main || wr_alt || (wave_mode && active_edge[0]); // R04 R05
  assign ovf_evt = tick && !reload && (count == timer8_pkg::COUNT_TOP); // R07

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      count <= timer8_pkg::COUNT_RELOAD; // R05 R11
    end else if (reload) begin
      count <= timer8_pkg::COUNT_RELOAD; // R04 R05
    end else if (tick) begin
      count <= count + 8'h01; // R02
    end
  end

  // Capture inputs are read whatever the pin's direction
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cap
      logic pin_in;
      logic sync1;
      logic sync2;
      logic prev;
      logic edge_sel;
      assign pin_in = BONDED[ch] ? (ch == 0 ? I_CAPTURE_PIN_ONE :
                      I_CAPTURE_PIN_TWO) : 1'b1; // R12 R21
      assign edge_sel = (ch == 0) ? ctrl_one[timer8_pkg::CR1_EDGE_ONE] :
                        ctrl_two[timer8_pkg::CR2_EDGE_TWO]; // R14
      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          sync1 <= 1'b1;
          sync2 <= 1'b1;
          prev <= 1'b1;
        end else begin
          sync1 <= pin_in;
          sync2 <= sync1;
          prev <= sync2;
        end
      end
      assign active_edge[ch] = edge_sel ? (sync2 && !prev) :
                               (!sync2 && prev); // R15
      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          cap_val[ch] <= timer8_pkg::CAP_RESET;
        end else if (cap_evt[ch]) begin
          cap_val[ch] <= count; // R13 R16 R19
        end
      end
    end
  endgenerate

  assign cap_evt[0] = active_edge[0] && !wave_mode; // R20
  assign cap_evt[1] = active_edge[1];

  assign set_evt = {cap_evt[1], cap_evt[0], ovf_evt}; // R07 R16
  assign clr_evt[0] = armed[0] && (rd_main || wr_main); // R03 R09
  assign clr_evt[1] = armed[1] && (rd_cap1 || wr_cap1); // R18
  assign clr_evt[2] = armed[2] && (rd_cap2 || wr_cap2); // R18

  // A status read arms the clear only for flags seen set by that read
  genvar fi;
  generate
    for (fi = 0; fi < 3; fi++) begin : g_flag
      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          armed[fi] <= 1'b0;
        end else if (rd_status && flags[fi]) begin
          armed[fi] <= 1'b1; // R09 R18
        end else if (clr_evt[fi]) begin
          armed[fi] <= 1'b0;
        end
      end
      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          flags[fi] <= 1'b0;
        end else if (set_evt[fi]) begin
          flags[fi] <= 1'b1; // R22
        end else if (clr_evt[fi]) begin
          flags[fi] <= 1'b0; // R09 R18
        end
      end
    end
  endgenerate

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_OVF_IRQ <= 1'b0;
      O_CAP_IRQ <= 1'b0;
    end else begin
      O_OVF_IRQ <= flags[0] && ctrl_one[timer8_pkg::CR1_OVF_IE] &&
                   !I_CPU_IRQ_MASK; // R08
      O_CAP_IRQ <= (flags[1] || flags[2]) &&
                   ctrl_one[timer8_pkg::CR1_CAP_IE] &&
                   !I_CPU_IRQ_MASK; // R17
    end
  end

  property p_count_write;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (wr_main || wr_alt) |=> (count == timer8_pkg::COUNT_RELOAD);
  endproperty
  a_count_write: assert property (p_count_write) // R04
    else $error("count write did not load reload value");

  property p_count_inc;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (tick && !reload) |=> (count == 8'($past(count) + 8'h01));
  endproperty
  a_count_inc: assert property (p_count_inc) // R02
    else $error("counter did not advance by one on tick");

  property p_ovf_set;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (tick && !reload && count == timer8_pkg::COUNT_TOP)
        |=> (flags[0] && count == 8'h00);
  endproperty
  a_ovf_set: assert property (p_ovf_set) // R07
    else $error("overflow flag missing on wrap");

  property p_alt_keeps_ovf;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (flags[0] && !rd_main && !wr_main) |=> flags[0];
  endproperty
  a_alt_keeps_ovf: assert property (p_alt_keeps_ovf) // R03
    else $error("overflow flag lost without main count access");

  property p_ovf_irq;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      O_OVF_IRQ |-> $past(flags[0]) && !$past(I_CPU_IRQ_MASK) &&
        $past(ctrl_one[timer8_pkg::CR1_OVF_IE]);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) // R08
    else $error("overflow request without its conditions");

  property p_cap_two;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      cap_evt[1] |=> (cap_val[1] == $past(count)) && flags[2];
  endproperty
  a_cap_two: assert property (p_cap_two) // R16
    else $error("capture two did not latch count and flag");

  property p_wave_no_cap1;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      wave_mode |=> $stable(cap_val[0]);
  endproperty
  a_wave_no_cap1: assert property (p_wave_no_cap1) // R20
    else $error("channel one captured in waveform mode");

  property p_halt_hold;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (I_HALT && !reload) [*2] |-> $stable(count);
  endproperty
  a_halt_hold: assert property (p_halt_hold) // R11
    else $error("counter moved while halted");

  property p_set_wins;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      (set_evt[1] && clr_evt[1]) |=> flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins) // R22
    else $error("capture one flag lost to a clear");

  property p_cap_irq;
    @(posedge I_REF_CLK) disable iff (!I_NRST)
      ((flags[1] || flags[2]) && ctrl_one[timer8_pkg::CR1_CAP_IE] &&
        !I_CPU_IRQ_MASK) |=> O_CAP_IRQ;
  endproperty
  a_cap_irq: assert property (p_cap_irq) // R17
    else $error("capture request not raised");

endmodule

`default_nettype wire

// file: inc/timer8_pkg.sv
// Constants shared by the 8-bit counter/capture timer
package timer8_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAP_ONE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MAIN_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ALT_COUNT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CAP_TWO = 8'h18;

  // control_reg_one fields
  localparam int CR1_CAP_IE = 7;
  localparam int CR1_OVF_IE = 5;
  localparam int CR1_EDGE_ONE = 1;
  // control_reg_two fields
  localparam int CR2_SINGLE_PULSE = 5;
  localparam int CR2_PWM = 4;
  localparam int CR2_TICK_LO = 2;
  localparam int CR2_EDGE_TWO = 1;
  // timer_status_reg fields
  localparam int SR_CAP_ONE = 7;
  localparam int SR_OVF = 5;
  localparam int SR_CAP_TWO = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CAP_RESET = 8'h00;
  localparam logic [7:0] COUNT_RELOAD = 8'hfc;
  localparam logic [7:0] COUNT_TOP = 8'hff;

  // tick_select encodings
  localparam logic [1:0] SEL_DIV4 = 2'h0;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h2;
  localparam logic [1:0] SEL_OSC = 2'h3;

  localparam int CPU_DIV2 = 2;
  localparam int CPU_DIV4 = 4;
  localparam int CPU_DIV8 = 8;
  localparam int OSC_DIV_DEFAULT = 8000;
  localparam int COUNT_SPAN = 256;
  localparam int PERIOD_DIV2 = CPU_DIV2 * COUNT_SPAN;
  localparam int PERIOD_DIV4 = CPU_DIV4 * COUNT_SPAN;
  localparam int PERIOD_DIV8 = CPU_DIV8 * COUNT_SPAN;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: bench/cap_source.sv
// Model of the signal sources on the capture pins and the oscillator pin
`timescale 1ns/1ps
`default_nettype none

module cap_source (
  input wire logic i_clk,
  output logic o_pin_one,
  output logic o_pin_two,
  output logic o_osc
);
  initial begin
    o_pin_one = 1'b1;
    o_pin_two = 1'b1;
    o_osc = 1'b0;
  end

  // Six clocks per level keeps edges far apart and lets the flag land
  task automatic drive(input int ch, input logic lvl);
    @(posedge i_clk);
    if (ch == 1) begin
      o_pin_one <= lvl;
    end else begin
      o_pin_two <= lvl;
    end
    repeat (6) @(posedge i_clk);
  endtask

  // Oscillator runs only on demand and stands low between bursts
  // Levels change on the falling edge so they never race the sampling edge
  task automatic osc(input int n);
    repeat (n) begin
      repeat (2) @(negedge i_clk);
      o_osc <= 1'b1;
      repeat (2) @(negedge i_clk);
      o_osc <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// file: bench/timer8_counter_capture_tb.sv
// Self-checking bench for the 8-bit counter and capture timer
`timescale 1ns/1ps
`default_nettype none

module timer8_counter_capture_tb;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } row_s;
  localparam logic [7:0] c1_a = timer8_pkg::OFF_CTRL_ONE;
  localparam logic [7:0] c2_a = timer8_pkg::OFF_CTRL_TWO;
  localparam logic [7:0] st_a = timer8_pkg::OFF_STATUS;
  localparam logic [7:0] k1_a = timer8_pkg::OFF_CAP_ONE;
  localparam logic [7:0] k2_a = timer8_pkg::OFF_CAP_TWO;
  localparam logic [7:0] main_a = timer8_pkg::OFF_MAIN_COUNT;
  localparam logic [7:0] alt_a = timer8_pkg::OFF_ALT_COUNT;
  localparam logic [1:0] ok = timer8_pkg::RESP_OKAY;
  localparam logic [1:0] bad = timer8_pkg::RESP_SLVERR;
  localparam logic [31:0] fo = 32'h1 << timer8_pkg::SR_OVF;
  localparam logic [31:0] f1 = 32'h1 << timer8_pkg::SR_CAP_ONE;
  localparam logic [31:0] f2 = 32'h1 << timer8_pkg::SR_CAP_TWO;
  localparam logic [31:0] fc = 32'(timer8_pkg::COUNT_RELOAD);
  localparam logic [31:0] osc_sel =
    32'(timer8_pkg::SEL_OSC) << timer8_pkg::CR2_TICK_LO;
  localparam logic [31:0] pwm_on = 32'h1 << timer8_pkg::CR2_PWM;
  localparam logic [31:0] c1_val = (32'h1 << timer8_pkg::CR1_CAP_IE) |
    (32'h1 << timer8_pkg::CR1_OVF_IE) | (32'h1 << timer8_pkg::CR1_EDGE_ONE);

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'b0;
  logic mask = 1'b1;
  logic halt = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, ovf_irq, cap_irq;
  wire pin1, pin2, osc;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  int cyc = 0;
  int t_take;
  int err_total = 0;
  int compares = 0;

  // Halt is held through the table so the count reads stay at reload
  row_s rows [11] = '{
    '{1'b0, c1_a, 32'h0, 32'h0, ok},
    '{1'b0, c2_a, 32'h0, 32'h0, ok},
    '{1'b0, st_a, 32'h0, 32'h0, ok},
    '{1'b0, k1_a, 32'h0, 32'h0, ok},
    '{1'b0, k2_a, 32'h0, 32'h0, ok},
    '{1'b0, main_a, 32'h0, fc, ok},
    '{1'b0, alt_a, 32'h0, fc, ok},
    '{1'b0, 8'h1c, 32'h0, 32'h0, bad},
    '{1'b1, 8'h1c, 32'hffffffff, 32'h0, bad},
    '{1'b1, c1_a, c1_val, 32'h0, ok},
    '{1'b0, c1_a, 32'h0, c1_val, ok}
  };
  logic [1:0] sel [3] = '{timer8_pkg::SEL_DIV2, timer8_pkg::SEL_DIV4,
    timer8_pkg::SEL_DIV8};
  int dv [3] = '{timer8_pkg::CPU_DIV2, timer8_pkg::CPU_DIV4,
    timer8_pkg::CPU_DIV8};

  timer8_counter_capture #(.OSC_DIV(4)) uut (
    .I_REF_CLK(ref_clk), .I_NRST(nrst),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(4'hf), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp), .I_CPU_IRQ_MASK(mask),
    .I_HALT(halt), .I_OSC_CLK(osc), .I_CAPTURE_PIN_ONE(pin1),
    .I_CAPTURE_PIN_TWO(pin2), .O_OVF_IRQ(ovf_irq), .O_CAP_IRQ(cap_irq)
  );

  cap_source src (
    .i_clk(ref_clk), .o_pin_one(pin1), .o_pin_two(pin2), .o_osc(osc)
  );

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end

  task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: response %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_b(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: request line %b expected %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge ref_clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // The address is offered at the edge that follows st
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, input int st);
    do @(posedge ref_clk); while (cyc < st);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    t_take = cyc;
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r, 0);
    chk_d(d, e);
    chk_r(r, ok);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0] r;
    int t1;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, r);
      end else begin
        rd(rows[i].a, a, r, 0);
        chk_d(a, rows[i].e);
      end
      chk_r(r, rows[i].r);
    end
    // Reads spaced a whole number of ticks apart give an exact count
    for (int i = 0; i < 3; i++) begin
      wr(c2_a, 32'(sel[i]) << timer8_pkg::CR2_TICK_LO, r);
      halt <= 1'b0;
      rd(alt_a, a, r, 0);
      t1 = t_take;
      rd(alt_a, b, r, t1 + 300 * dv[i] - 1);
      chk_d(b, {24'h0, a[7:0] + 8'((t_take - t1) / dv[i])});
      halt <= 1'b1;
      rd(alt_a, a, r, 0);
      rd(alt_a, b, r, t_take + 40);
      chk_d(b, a);
      wr(i[0] ? alt_a : main_a, 32'h37, r);
      rdc(alt_a, fc);
    end
    wr(c2_a, osc_sel, r);
    halt <= 1'b0;
    rdc(st_a, fo);
    chk_b(ovf_irq, 1'b0);
    rdc(main_a, fc);
    rdc(st_a, 32'h0);
    wr(main_a, 32'h0, r);
    src.osc(20);
    rdc(alt_a, 32'h01);
    rdc(main_a, 32'h01);
    rdc(st_a, fo);
    rdc(alt_a, 32'h01);
    rdc(st_a, fo);
    mask <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_b(ovf_irq, 1'b1);
    rdc(main_a, 32'h01);
    rdc(st_a, 32'h0);
    chk_b(ovf_irq, 1'b0);
    src.drive(1, 1'b0);
    rdc(st_a, 32'h0);
    src.drive(1, 1'b1);
    rdc(k1_a, 32'h01);
    rdc(st_a, f1);
    chk_b(cap_irq, 1'b1);
    src.drive(2, 1'b0);
    src.osc(4);
    src.drive(2, 1'b1);
    rdc(k2_a, 32'h01);
    src.osc(4);
    src.drive(2, 1'b0);
    rdc(k2_a, 32'h03);
    rdc(st_a, f1 | f2);
    rdc(k2_a, 32'h03);
    rdc(st_a, f1);
    chk_b(cap_irq, 1'b1);
    rdc(k1_a, 32'h01);
    rdc(st_a, 32'h0);
    chk_b(cap_irq, 1'b0);
    wr(c2_a, osc_sel | pwm_on, r);
    src.drive(1, 1'b0);
    src.drive(1, 1'b1);
    rdc(st_a, 32'h0);
    rdc(alt_a, fc);
    src.drive(2, 1'b1);
    src.drive(2, 1'b0);
    rdc(k2_a, fc);
    rdc(st_a, f2);
    mask <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_b(cap_irq, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
